// *** rtl/flash_writer_map.vh ***
// Constants for the writer-mode flash programming controller
// How it works
// - Vpp pin never driven to ground
// - Code 0x00 then reads return data
// - Erase: code 0x20 written twice
// - Auto-erase: code 0x30 written twice
// - Program: 0x40, then address and byte
// - Program-verify: 0xC0, then read check byte
// - Oe high six microseconds before verify
// - Strobes high while vpp moves
`ifndef FLASH_WRITER_MAP_VH
`define FLASH_WRITER_MAP_VH

// =====================================================
// Clock and pin timing, each in its own unit
`define CLK_PERIOD_NS 32'h0000000a
`define T_WEP_NS 32'h00000046
`define T_WEH_NS 32'h00000028
`define T_CWC_NS 32'h00000078
`define T_VPS_NS 32'h00000064
`define T_VPH_NS 32'h00000064
`define T_OERS_US 32'h00000006
`define T_VA_NS 32'h000001f4
`define T_PPW_NS 32'h00000019
`define T_ET_MS 32'h00000009
`define T_AET_S 32'h0000001e
`define NS_PER_US 32'h000003e8
`define NS_PER_MS 32'h000f4240
`define NS_PER_S 32'h3b9aca00

// =====================================================
// Cycle counts, least times rounded up
`define CEIL_CYC(t) (((t) + `CLK_PERIOD_NS - 32'h00000001) / `CLK_PERIOD_NS)
`define WEP_CYC `CEIL_CYC(`T_WEP_NS)
`define WEH_CYC `CEIL_CYC(`T_WEH_NS)
`define CWC_REST_CYC `CEIL_CYC(`T_CWC_NS - `T_WEP_NS)
`define VPS_CYC `CEIL_CYC(`T_VPS_NS)
`define VPH_CYC `CEIL_CYC(`T_VPH_NS)
`define OERS_CYC `CEIL_CYC(`T_OERS_US * `NS_PER_US)
`define VA_CYC `CEIL_CYC(`T_VA_NS)
`define PPW_CYC `CEIL_CYC(`T_PPW_NS)
`define ET_CYC `CEIL_CYC(`T_ET_MS * `NS_PER_MS)
`define AET_CYC (`T_AET_S * (`NS_PER_S / `CLK_PERIOD_NS))
`define SYNC_CYC 32'h00000004
`define ONE_CYC 32'h00000001

// =====================================================
// Command codes written on the data bus
`define CODE_READ 8'h00
`define CODE_ERASE 8'h20
`define CODE_ERASE_CHECK 8'ha0
`define CODE_AUTO_ERASE 8'h30
`define CODE_PROGRAM 8'h40
`define CODE_PROGRAM_CHECK 8'hc0
`define CODE_RESET 8'hff
`define ERASED_BYTE 8'hff

// =====================================================
// User operation codes
`define OP_READ 3'h0
`define OP_ERASE 3'h1
`define OP_ERASE_CHECK 3'h2
`define OP_AUTO_ERASE 3'h3
`define OP_PROGRAM 3'h4
`define OP_PROGRAM_CHECK 3'h5
`define OP_RESET 3'h6
`define OP_LAST 3'h6

`define ADDR_W 17
`define DATA_W 8

`endif

// *** rtl/pin_sync.v ***
// Three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input wire clock,
	input wire resetn,
	// Raw pins and filtered result
	input wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] stable
);

	// =====================================================
	// One chain per bit; stage one is read only by stage two
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg s1_ff;
			reg s2_ff;
			reg s3_ff;
			reg hold_ff;
			always @(posedge clock) begin
				if (!resetn) begin
					s1_ff <= 1'b0;
					s2_ff <= 1'b0;
					s3_ff <= 1'b0;
					hold_ff <= 1'b0;
				end else begin
					s1_ff <= pin_in[i];
					s2_ff <= s1_ff;
					s3_ff <= s2_ff;
					// A change counts only once two stages agree
					if (s2_ff == s3_ff) begin
						hold_ff <= s3_ff;
					end
				end
			end
			assign stable[i] = hold_ff;
		end
	endgenerate

endmodule // pin_sync
`default_nettype wire

// *** rtl/flash_writer_host.v ***
// Programmer-side controller driving the flash writer-mode pins
`timescale 1ns/100ps
`default_nettype none
`include "flash_writer_map.vh"
module flash_writer_host #(
	// Long waits, shortened in simulation
	parameter [31:0] ERASE_WAIT_CYC = `ET_CYC,
	parameter [31:0] AUTO_ERASE_WAIT_CYC = `AET_CYC
) (
	// Clock and reset
	input wire clock,
	input wire resetn,
	// User command request
	input wire cmd_valid,
	input wire [2:0] cmd_op,
	input wire [`ADDR_W-1:0] cmd_addr,
	input wire [`DATA_W-1:0] cmd_data,
	output reg cmd_ready,
	// User response
	output reg rsp_valid,
	output reg [`DATA_W-1:0] rsp_data,
	output reg rsp_blank,
	// Device strobes, active low
	output reg chip_enable_n,
	output reg output_enable_n,
	output reg write_enable_n,
	// Device address bus
	output reg [`ADDR_W-1:0] flash_addr,
	// Device data bus, split into three signals
	input wire [`DATA_W-1:0] flash_data_in,
	output reg [`DATA_W-1:0] flash_data_out,
	output reg flash_data_oe,
	// Program voltage select: high gives 12 V, low gives logic supply
	output reg program_voltage_pin
);

	// =====================================================
	// Sequencer states
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_VPP_UP = 3'h1;
	localparam [2:0] ST_WR_LOW = 3'h2;
	localparam [2:0] ST_WR_HIGH = 3'h3;
	localparam [2:0] ST_SETTLE = 3'h4;
	localparam [2:0] ST_RD_LOW = 3'h5;
	localparam [2:0] ST_VPP_DOWN = 3'h6;
	localparam [2:0] ST_DONE = 3'h7;

	reg [2:0] state_ff;
	reg [31:0] cnt_ff;
	reg [2:0] op_ff;
	reg [`ADDR_W-1:0] addr_ff;
	reg [`DATA_W-1:0] data_ff;
	reg second_ff;
	wire [`DATA_W-1:0] data_sync;

	// =====================================================
	// Read data arrives from another domain, so it is filtered
	pin_sync #(
		.WIDTH(`DATA_W)
	) u_data_sync (
		.clock(clock),
		.resetn(resetn),
		.pin_in(flash_data_in),
		.stable(data_sync)
	);

	// =====================================================
	// Decode of the latched operation
	reg [`DATA_W-1:0] first_code;
	reg two_writes;
	reg ends_in_read;
	reg [31:0] settle_cyc;
	always @* begin
		first_code = `CODE_READ;
		two_writes = 1'b0;
		ends_in_read = 1'b0;
		settle_cyc = `ONE_CYC;
		case (op_ff)
			`OP_READ: begin
				first_code = `CODE_READ;
				ends_in_read = 1'b1;
			end
			`OP_ERASE: begin
				first_code = `CODE_ERASE;
				two_writes = 1'b1;
				settle_cyc = ERASE_WAIT_CYC;
			end
			`OP_ERASE_CHECK: begin
				first_code = `CODE_ERASE_CHECK;
				ends_in_read = 1'b1;
				settle_cyc = `OERS_CYC;
			end
			`OP_AUTO_ERASE: begin
				first_code = `CODE_AUTO_ERASE;
				two_writes = 1'b1;
				settle_cyc = AUTO_ERASE_WAIT_CYC;
			end
			`OP_PROGRAM: begin
				first_code = `CODE_PROGRAM;
				two_writes = 1'b1;
				settle_cyc = `PPW_CYC;
			end
			`OP_PROGRAM_CHECK: begin
				first_code = `CODE_PROGRAM_CHECK;
				ends_in_read = 1'b1;
				settle_cyc = `OERS_CYC;
			end
			`OP_RESET: begin
				first_code = `CODE_RESET;
				two_writes = 1'b1;
			end
			default: begin
				first_code = `CODE_READ;
			end
		endcase
	end

	// =====================================================
	// Second write: program carries target address and byte, others repeat the code
	wire [`DATA_W-1:0] second_data = (op_ff == `OP_PROGRAM) ? data_ff : first_code;
	wire [`ADDR_W-1:0] second_addr = (op_ff == `OP_PROGRAM) ? addr_ff : {`ADDR_W{1'b0}};
	wire [`ADDR_W-1:0] first_addr = (op_ff == `OP_ERASE_CHECK) ? addr_ff : {`ADDR_W{1'b0}};
	wire op_legal = (cmd_op <= `OP_LAST);
	wire cnt_zero = (cnt_ff == 32'h00000000);

	// =====================================================
	// Pin sequencer; every pin comes from a flip-flop
	always @(posedge clock) begin
		if (!resetn) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 32'h00000000;
			op_ff <= `OP_READ;
			addr_ff <= {`ADDR_W{1'b0}};
			data_ff <= {`DATA_W{1'b0}};
			second_ff <= 1'b0;
			cmd_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= {`DATA_W{1'b0}};
			rsp_blank <= 1'b0;
			chip_enable_n <= 1'b1;
			output_enable_n <= 1'b1;
			write_enable_n <= 1'b1;
			flash_addr <= {`ADDR_W{1'b0}};
			flash_data_out <= {`DATA_W{1'b0}};
			flash_data_oe <= 1'b0;
			program_voltage_pin <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			if (!cnt_zero) begin
				cnt_ff <= cnt_ff - `ONE_CYC;
			end
			case (state_ff)
				ST_IDLE: begin
					// Ready rises one cycle after reset release
					cmd_ready <= 1'b1;
					if (cmd_valid && cmd_ready && op_legal) begin
						op_ff <= cmd_op;
						addr_ff <= cmd_addr;
						data_ff <= cmd_data;
						cmd_ready <= 1'b0;
						second_ff <= 1'b0;
						// Strobes are all high here, so the supply may move
						program_voltage_pin <= 1'b1;
						cnt_ff <= `VPS_CYC - `ONE_CYC;
						state_ff <= ST_VPP_UP;
					end
				end
				ST_VPP_UP: begin
					if (cnt_zero) begin
						// First command write cycle
						chip_enable_n <= 1'b0;
						write_enable_n <= 1'b0;
						flash_addr <= first_addr;
						flash_data_out <= first_code;
						flash_data_oe <= 1'b1;
						cnt_ff <= `WEP_CYC - `ONE_CYC;
						state_ff <= ST_WR_LOW;
					end
				end
				ST_WR_LOW: begin
					if (cnt_zero) begin
						// Rising edge latches the byte; data stays for hold time
						write_enable_n <= 1'b1;
						cnt_ff <= ((`CWC_REST_CYC > `WEH_CYC) ? `CWC_REST_CYC : `WEH_CYC) - `ONE_CYC;
						state_ff <= ST_WR_HIGH;
					end
				end
				ST_WR_HIGH: begin
					if (cnt_zero) begin
						if (two_writes && !second_ff) begin
							second_ff <= 1'b1;
							write_enable_n <= 1'b0;
							flash_addr <= second_addr;
							flash_data_out <= second_data;
							cnt_ff <= `WEP_CYC - `ONE_CYC;
							state_ff <= ST_WR_LOW;
						end else begin
							// Release the bus before the device may drive it
							flash_data_oe <= 1'b0;
							cnt_ff <= settle_cyc - `ONE_CYC;
							state_ff <= ST_SETTLE;
						end
					end
				end
				ST_SETTLE: begin
					// Output enable stays high through the verify setup wait
					if (cnt_zero) begin
						if (ends_in_read) begin
							if (op_ff == `OP_READ) begin
								flash_addr <= addr_ff;
							end
							output_enable_n <= 1'b0;
							// Data may appear only at the end of the access time, so the three synchroniser
							// stages and the filter register need four whole cycles on top of it
							cnt_ff <= `VA_CYC + `SYNC_CYC;
							state_ff <= ST_RD_LOW;
						end else begin
							chip_enable_n <= 1'b1;
							cnt_ff <= `VPH_CYC - `ONE_CYC;
							state_ff <= ST_VPP_DOWN;
						end
					end
				end
				ST_RD_LOW: begin
					// Access time plus synchroniser depth before sampling
					if (cnt_zero) begin
						rsp_data <= data_sync;
						rsp_blank <= (data_sync == `ERASED_BYTE);
						output_enable_n <= 1'b1;
						chip_enable_n <= 1'b1;
						cnt_ff <= `VPH_CYC - `ONE_CYC;
						state_ff <= ST_VPP_DOWN;
					end
				end
				ST_VPP_DOWN: begin
					if (cnt_zero) begin
						// Back to logic supply level, never ground
						program_voltage_pin <= 1'b0;
						cnt_ff <= `VPS_CYC - `ONE_CYC;
						state_ff <= ST_DONE;
					end
				end
				ST_DONE: begin
					// Voltage settles before the next operation may start
					if (cnt_zero) begin
						rsp_valid <= 1'b1;
						cmd_ready <= 1'b1;
						state_ff <= ST_IDLE;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

endmodule // flash_writer_host
`default_nettype wire

// *** tb/host_props.sv ***
// Pin and handshake checker for the flash writer host
`timescale 1ns/100ps
`default_nettype none
// ==========
// Checker
module host_props (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// User side
	input wire logic cmd_valid,
	input wire logic [2:0] cmd_op,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic rsp_blank,
	// Device side
	input wire logic chip_enable_n,
	input wire logic output_enable_n,
	input wire logic write_enable_n,
	input wire logic [7:0] flash_data_out,
	input wire logic flash_data_oe,
	input wire logic program_voltage_pin
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	logic [7:0] code_ff;
	logic [9:0] gap_ff;
	// Last byte written and cycles since; saturates so it never wraps
	always @(posedge clock) begin
		if (!resetn) begin
			code_ff <= 8'h00;
			gap_ff <= 10'h000;
		end else if (!write_enable_n) begin
			code_ff <= flash_data_out;
			gap_ff <= 10'h000;
		end else if (gap_ff != 10'h3ff) begin
			gap_ff <= gap_ff + 10'h001;
		end
	end
	a_vpp_quiet: assert property ($changed(program_voltage_pin) |-> chip_enable_n && output_enable_n && write_enable_n)
		else $error("vpp moved with a strobe low");
	a_write_mode: assert property (!write_enable_n |-> program_voltage_pin && !chip_enable_n && output_enable_n && flash_data_oe)
		else $error("bad pin state in write");
	a_read_bus: assert property (!output_enable_n |-> !chip_enable_n && write_enable_n && !flash_data_oe)
		else $error("bad pin state in read");
	a_we_low: assert property ($fell(write_enable_n) |-> !write_enable_n [*7])
		else $error("write pulse too short");
	a_we_high: assert property ($rose(write_enable_n) |-> write_enable_n [*4])
		else $error("write high time too short");
	a_verify_wait: assert property ($fell(output_enable_n) && (code_ff == 8'ha0 || code_ff == 8'hc0) |-> gap_ff >= 10'd599)
		else $error("verify read too early");
	a_take_busy: assert property (cmd_valid && cmd_ready && cmd_op != 3'h7 |=> !cmd_ready ##[50:1000] rsp_valid)
		else $error("operation not completed");
	a_refuse_op: assert property (cmd_valid && cmd_ready && cmd_op == 3'h7 |=> cmd_ready && !rsp_valid)
		else $error("unlisted operation taken");
	a_blank_flag: assert property (rsp_valid |-> rsp_blank == (rsp_data == 8'hff))
		else $error("blank flag wrong");
	c_verify: cover property ($fell(output_enable_n) && code_ff == 8'hc0);
	c_erase: cover property ($rose(write_enable_n) && code_ff == 8'h20);
	c_refuse: cover property (cmd_valid && cmd_ready && cmd_op == 3'h7);
endmodule // host_props
bind flash_writer_host host_props chk (.clock, .resetn, .cmd_valid, .cmd_op, .cmd_ready, .rsp_valid, .rsp_data,
	.rsp_blank, .chip_enable_n, .output_enable_n, .write_enable_n, .flash_data_out, .flash_data_oe, .program_voltage_pin);
`default_nettype wire

// *** tb/flash_dev_model.sv ***
// Behavioural model of the flash device in writer mode
`timescale 1ns/100ps
`default_nettype none
// ==========
// Device model
module flash_dev_model #(
	parameter int ACCESS_CYC = 50
) (
	// Clock for access delay and floating pattern
	input wire logic clock,
	// Strobes and pins
	input wire logic chip_enable_n,
	input wire logic output_enable_n,
	input wire logic write_enable_n,
	input wire logic program_voltage_pin,
	input wire logic [16:0] flash_addr,
	// Host half of the data bus, resolved wire out
	input wire logic [7:0] flash_data_out,
	input wire logic flash_data_oe,
	output logic [7:0] bus
);
	logic [7:0] mem [int];
	logic [7:0] pend_ff = 8'h00;
	logic [7:0] float_ff = 8'h5a;
	logic [1:0] mode_ff = 2'h0;
	logic [16:0] chk_ff = 17'h00000;
	int acc = 0;
	function automatic logic [7:0] rd(input int a);
		return mem.exists(a) ? mem[a] : 8'hff;
	endfunction
	// Command latch on the rising write strobe
	always @(posedge write_enable_n) begin
		if (!chip_enable_n && program_voltage_pin) begin
			if (pend_ff == 8'h40) begin
				mem[flash_addr] = flash_data_out;
				chk_ff = flash_addr;
				pend_ff = 8'h00;
			end else if (pend_ff != 8'h00 && pend_ff == flash_data_out) begin
				if (pend_ff != 8'hff)
					mem.delete();
				mode_ff = 2'h0;
				pend_ff = 8'h00;
			end else begin
				pend_ff = 8'h00;
				case (flash_data_out)
				8'h00: mode_ff = 2'h0;
				8'ha0: begin
					mode_ff = 2'h1;
					chk_ff = flash_addr;
				end
				8'hc0: mode_ff = 2'h2;
				8'h20, 8'h30, 8'h40, 8'hff: pend_ff = flash_data_out;
				default: ;
				endcase
			end
		end
	end
	// Slow access; a released bus shows a changing pattern, not the old byte
	always @(posedge clock) begin
		float_ff <= float_ff + 8'h3b;
		acc <= (!chip_enable_n && !output_enable_n && write_enable_n) ? acc + 1 : 0;
	end
	// Resolve the shared data wire
	always @* begin
		if (flash_data_oe)
			bus = flash_data_out;
		else if (!chip_enable_n && !output_enable_n && write_enable_n && acc >= ACCESS_CYC)
			bus = (mode_ff == 2'h0) ? rd(flash_addr) : rd(chk_ff);
		else
			bus = float_ff;
	end
endmodule // flash_dev_model
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking testbench for the flash writer host
`timescale 1ns/100ps
`default_nettype none
// ==========
// Bench top
module tb;
	logic clock, resetn, cmd_valid, cmd_ready, rsp_valid, rsp_blank;
	logic chip_enable_n, output_enable_n, write_enable_n, flash_data_oe, program_voltage_pin;
	logic [2:0] cmd_op;
	logic [16:0] cmd_addr, flash_addr;
	logic [7:0] cmd_data, rsp_data, flash_data_in, flash_data_out;
	int n_fail, n_compared;
	flash_writer_host #(.ERASE_WAIT_CYC(32'h14), .AUTO_ERASE_WAIT_CYC(32'h14)) dut (.clock(clock), .resetn(resetn),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_blank(rsp_blank), .chip_enable_n(chip_enable_n),
		.output_enable_n(output_enable_n), .write_enable_n(write_enable_n), .flash_addr(flash_addr),
		.flash_data_in(flash_data_in), .flash_data_out(flash_data_out), .flash_data_oe(flash_data_oe),
		.program_voltage_pin(program_voltage_pin));
	flash_dev_model dev (.clock(clock), .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
		.write_enable_n(write_enable_n), .program_voltage_pin(program_voltage_pin), .flash_addr(flash_addr),
		.flash_data_out(flash_data_out), .flash_data_oe(flash_data_oe), .bus(flash_data_in));
	// Free-running clock
	always #5 clock = ~clock;
	task check(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("Counts: %0d compared, %0d failed", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// One operation; read-type results are judged against exp
	task automatic run_op(input logic [2:0] op, input logic [16:0] a, input logic [7:0] d, input logic [7:0] exp);
		int i;
		@(negedge clock);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_addr = a;
		cmd_data = d;
		i = 0;
		while (cmd_ready !== 1'b1 && i < 100) begin
			@(negedge clock);
			i++;
		end
		if (cmd_ready !== 1'b1) begin
			check({7'h00, cmd_ready}, 8'h01);
			stop_test();
		end
		@(negedge clock);
		cmd_valid = 1'b0;
		i = 0;
		while (rsp_valid !== 1'b1 && i < 3000) begin
			@(posedge clock);
			#1;
			i++;
		end
		if (rsp_valid !== 1'b1) begin
			check({7'h00, rsp_valid}, 8'h01);
			stop_test();
		end
		if (op == 3'h0 || op == 3'h2 || op == 3'h5) begin
			check(rsp_data, exp);
			check({7'h00, rsp_blank}, {7'h00, exp == 8'hff});
		end
	endtask
	task blank_read;
		run_op(3'h0, 17'h1ffff, 8'h00, 8'hff);
	endtask
	task prog_verify;
		run_op(3'h4, 17'h00123, 8'h5a, 8'h00);
		run_op(3'h5, 17'h00000, 8'h00, 8'h5a);
		run_op(3'h0, 17'h00123, 8'h00, 8'h5a);
	endtask
	task erase_check;
		run_op(3'h2, 17'h00123, 8'h00, 8'h5a);
		run_op(3'h1, 17'h00000, 8'h00, 8'h00);
		run_op(3'h2, 17'h00123, 8'h00, 8'hff);
	endtask
	task auto_erase;
		run_op(3'h4, 17'h10000, 8'h00, 8'h00);
		run_op(3'h0, 17'h10000, 8'h00, 8'h00);
		run_op(3'h3, 17'h00000, 8'h00, 8'h00);
		run_op(3'h0, 17'h10000, 8'h00, 8'hff);
	endtask
	task reset_cmd;
		run_op(3'h4, 17'h00042, 8'ha5, 8'h00);
		run_op(3'h6, 17'h00000, 8'h00, 8'h00);
		run_op(3'h0, 17'h00042, 8'h00, 8'ha5);
	endtask
	// Unlisted operation must sit untaken
	task refuse_op;
		@(negedge clock);
		cmd_valid = 1'b1;
		cmd_op = 3'h7;
		repeat (20) @(negedge clock);
		check({7'h00, cmd_ready}, 8'h01);
		check({7'h00, chip_enable_n}, 8'h01);
		cmd_valid = 1'b0;
	endtask
	// Reset in mid-operation, then the array must still read back
	task mid_reset;
		@(negedge clock);
		cmd_valid = 1'b1;
		cmd_op = 3'h0;
		@(negedge clock);
		cmd_valid = 1'b0;
		repeat (30) @(negedge clock);
		resetn = 1'b0;
		repeat (8) @(negedge clock);
		check({5'h00, chip_enable_n, output_enable_n, write_enable_n}, 8'h07);
		check({6'h00, program_voltage_pin, cmd_ready}, 8'h00);
		resetn = 1'b1;
		run_op(3'h0, 17'h00042, 8'h00, 8'ha5);
	endtask
	// Main sequence
	initial begin
		clock = 1'b0;
		resetn = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 3'h0;
		cmd_addr = 17'h00000;
		cmd_data = 8'h00;
		n_fail = 0;
		n_compared = 0;
		repeat (8) @(negedge clock);
		resetn = 1'b1;
		blank_read();
		prog_verify();
		erase_check();
		auto_erase();
		reset_cmd();
		refuse_op();
		mid_reset();
		stop_test();
	end
endmodule // tb
`default_nettype wire
